// ---- src/axr_ctrl.sv ----
// Auxiliary regulator control: configuration lock, mode behaviour,
// flags and APB register access.
// Assumes srst is the power-on reset and soft_rst a one-cycle pulse.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "axr_defines.svh"

// Notes on behaviour
// - Enable written in Normal selects stand-alone
// - Share select sets load-sharing, enable stays zero
// - First selection locks the configuration
// - Lock survives soft reset while powered
// - Level bit picks 3.3V/1.8V, stand-alone only
// - Regulator state follows system mode per configuration
// - Stand-alone regulator still switchable on/off
// - Stand-alone reconfiguration ignored, no error flag
// - Load-sharing reconfiguration sets error, unchanged
// - Share off in Stop unless kept, auto-return
// - Supply low turns off unless keep-on set
// - Stand-alone shunt limit sets overcurrent flag only
// - Stand-alone undervoltage sets undervoltage flag
// - Load-sharing: no undervoltage flag, off in Fail-Safe
// - Load-sharing never sets overcurrent flag
// - Stop low-power with high-power assist; Normal high-power
module axr_ctrl (
  // Clock and power-on reset
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // System state
  input  wire axr_pkg::axr_mode_t sys_mode,
  input  wire logic              soft_rst,
  // Analog monitors
  input  wire logic              supply_low,
  input  wire logic              shunt_limit,
  input  wire logic              reg_uv,
  input  wire logic              drive_rise,
  input  wire logic              drive_fall,
  // Regulator controls
  output logic                   reg_on,
  output logic                   level_1v8,
  output logic                   hp_on,
  output logic                   lp_on,
  // Interrupt
  output logic                   irq
);
  import axr_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  axr_main_st_t        st_ff;
  axr_main_st_t        nxt_st;
  logic                setup;
  logic                wr_en;
  logic                hit_ctrl;
  logic                hit_hw;
  logic                hit_stat;
  logic                hit_clr;
  logic                hit_ien;
  logic                mapped;
  logic                cmd_err;
  logic                low_pwr;
  logic [`AXR_NEV-1:0] ev_set;
  logic [`AXR_NEV-1:0] ev_clr;
  logic [`AXR_NEV-1:0] sts;
  logic [`AXR_NEV-1:0] ien;

  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
    return a == off;
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pwrite;
  assign hit_ctrl = addr_hit(paddr, `AXR_OFF_CTRL);
  assign hit_hw   = addr_hit(paddr, `AXR_OFF_HWCTL);
  assign hit_stat = addr_hit(paddr, `AXR_OFF_STAT);
  assign hit_clr  = addr_hit(paddr, `AXR_OFF_CLR);
  assign hit_ien  = addr_hit(paddr, `AXR_OFF_IEN);
  assign mapped   = hit_ctrl || hit_hw || hit_stat || hit_clr || hit_ien;
  // Read data is captured in the setup cycle, so no wait state
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = st_ff.rdata;

  // ****************************************
  // Configuration, mode and output logic
  // ****************************************
  always_comb begin
    nxt_st  = st_ff;
    cmd_err = 1'b0;

    if (setup && !pwrite) begin
      nxt_st.rdata = `AXR_RD_RST;
      if (hit_ctrl) begin
        nxt_st.rdata[`AXR_CTRL_EN]  = st_ff.en;
        nxt_st.rdata[`AXR_CTRL_LVL] = st_ff.lvl;
      end else if (hit_hw) begin
        nxt_st.rdata[`AXR_HW_LS]      = st_ff.cfg == AXR_CFG_SHARE;
        nxt_st.rdata[`AXR_HW_STPKEEP] = st_ff.stop_keep;
        nxt_st.rdata[`AXR_HW_UVKEEP]  = st_ff.uv_keep;
      end else if (hit_stat) begin
        nxt_st.rdata[`AXR_NEV-1:0]    = sts;
        nxt_st.rdata[`AXR_STAT_LOCK]  = st_ff.cfg != AXR_CFG_NONE;
        nxt_st.rdata[`AXR_STAT_SHARE] = st_ff.cfg == AXR_CFG_SHARE;
        nxt_st.rdata[`AXR_STAT_ON]    = st_ff.on;
        nxt_st.rdata[`AXR_STAT_HP]    = hp_on;
        nxt_st.rdata[`AXR_STAT_LP]    = lp_on;
      end else if (hit_ien) begin
        nxt_st.rdata[`AXR_NEV-1:0] = ien;
      end
    end

    if (wr_en && hit_ctrl) begin
      nxt_st.lvl = pwdata[`AXR_CTRL_LVL];
      unique case (st_ff.cfg)
        AXR_CFG_NONE: begin
          // Enable outside Normal does not select a configuration
          if (pwdata[`AXR_CTRL_EN] && sys_mode == AXR_MODE_NORMAL) begin
            nxt_st.cfg = AXR_CFG_ALONE;
            nxt_st.en  = 1'b1;
          end
        end
        AXR_CFG_ALONE: begin
          nxt_st.en = pwdata[`AXR_CTRL_EN];
        end
        AXR_CFG_SHARE: begin
          if (pwdata[`AXR_CTRL_EN]) begin
            cmd_err = 1'b1;
          end
        end
        default: begin
          nxt_st.cfg = AXR_CFG_NONE;
        end
      endcase
    end

    if (wr_en && hit_hw) begin
      nxt_st.stop_keep = pwdata[`AXR_HW_STPKEEP];
      nxt_st.uv_keep   = pwdata[`AXR_HW_UVKEEP];
      unique case (st_ff.cfg)
        AXR_CFG_NONE: begin
          if (pwdata[`AXR_HW_LS]) begin
            nxt_st.cfg = AXR_CFG_SHARE;
            nxt_st.en  = 1'b0;
          end
        end
        AXR_CFG_ALONE: begin
          // Share select silently dropped once stand-alone is locked
          nxt_st.cfg = AXR_CFG_ALONE;
        end
        AXR_CFG_SHARE: begin
          if (!pwdata[`AXR_HW_LS]) begin
            cmd_err = 1'b1;
          end
        end
        default: begin
          nxt_st.cfg = AXR_CFG_NONE;
        end
      endcase
    end

    // Soft reset returns control bits only; the lock stays
    if (soft_rst) begin
      nxt_st.en        = 1'b0;
      nxt_st.lvl       = 1'b0;
      nxt_st.stop_keep = 1'b0;
      nxt_st.uv_keep   = 1'b0;
    end

    unique case (sys_mode)
      AXR_MODE_INIT, AXR_MODE_FAIL: begin
        nxt_st.want = 1'b0;
      end
      AXR_MODE_NORMAL: begin
        if (st_ff.cfg == AXR_CFG_ALONE) begin
          nxt_st.want = nxt_st.en;
        end else begin
          // Load sharing comes back on by itself after Stop
          nxt_st.want = st_ff.cfg == AXR_CFG_SHARE;
        end
      end
      AXR_MODE_STOP: begin
        if (st_ff.cfg == AXR_CFG_SHARE && !st_ff.stop_keep) begin
          nxt_st.want = 1'b0;
        end
      end
      AXR_MODE_SLEEP: begin
        if (st_ff.cfg == AXR_CFG_SHARE) begin
          nxt_st.want = 1'b0;
        end
      end
      AXR_MODE_RESTART: begin
        if (st_ff.cfg == AXR_CFG_SHARE) begin
          nxt_st.want = 1'b1;
        end
      end
      default: begin
        nxt_st.want = 1'b0;
      end
    endcase

    // Supply drop gates the output but keeps the wish, so it
    // returns on its own when the supply recovers
    nxt_st.on  = nxt_st.want && !(supply_low && !st_ff.uv_keep);
    nxt_st.v18 = st_ff.cfg == AXR_CFG_ALONE && nxt_st.lvl;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_on    = st_ff.on;
  assign level_1v8 = st_ff.v18;

  // ****************************************
  // Events and interrupt
  // ****************************************
  always_comb begin
    ev_set = `AXR_EV_RST;
    // Overcurrent and undervoltage flags exist only in stand-alone
    ev_set[`AXR_EV_OC]  = shunt_limit && st_ff.cfg == AXR_CFG_ALONE;
    ev_set[`AXR_EV_UV]  = reg_uv && st_ff.on &&
                          st_ff.cfg == AXR_CFG_ALONE;
    ev_set[`AXR_EV_ERR] = cmd_err;
    // Overcurrent cannot be cleared while the limit persists
    ev_clr = (wr_en && hit_clr) ? pwdata[`AXR_NEV-1:0] : `AXR_EV_RST;
  end

  axr_irq u_irq (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .ev_set   (ev_set),
    .ev_clr   (ev_clr),
    .ien_wr   (wr_en && hit_ien),
    .ien_data (pwdata[`AXR_NEV-1:0]),
    .sts      (sts),
    .ien      (ien),
    .irq      (irq)
  );

  // ****************************************
  // Power stage selection
  // ****************************************
  assign low_pwr = sys_mode == AXR_MODE_STOP ||
                   sys_mode == AXR_MODE_SLEEP;

  axr_pwr_sel u_pwr (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .reg_on     (st_ff.on),
    .low_pwr    (low_pwr),
    .drive_rise (drive_rise),
    .drive_fall (drive_fall),
    .hp_on      (hp_on),
    .lp_on      (lp_on)
  );

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_lock_holds: assert property (
    st_ff.cfg != AXR_CFG_NONE |=> st_ff.cfg == $past(st_ff.cfg))
    else $error("locked configuration changed");

  a_alone_select: assert property (
    wr_en && hit_ctrl && pwdata[`AXR_CTRL_EN] &&
    st_ff.cfg == AXR_CFG_NONE && sys_mode == AXR_MODE_NORMAL
    |=> st_ff.cfg == AXR_CFG_ALONE)
    else $error("stand-alone not selected");

  a_share_select: assert property (
    wr_en && hit_hw && pwdata[`AXR_HW_LS] && st_ff.cfg == AXR_CFG_NONE
    |=> st_ff.cfg == AXR_CFG_SHARE && !st_ff.en)
    else $error("load sharing not selected");

  a_level_share: assert property (
    st_ff.cfg == AXR_CFG_SHARE |=> !level_1v8)
    else $error("level bit used in load sharing");

  a_off_init_fs: assert property (
    sys_mode == AXR_MODE_INIT || sys_mode == AXR_MODE_FAIL
    |=> !reg_on)
    else $error("regulator on in Init or Fail-Safe");

  a_alone_silent: assert property (
    st_ff.cfg == AXR_CFG_ALONE |-> !ev_set[`AXR_EV_ERR])
    else $error("error flag raised in stand-alone");

  a_share_error: assert property (
    wr_en && hit_hw && !pwdata[`AXR_HW_LS] &&
    st_ff.cfg == AXR_CFG_SHARE
    |-> ev_set[`AXR_EV_ERR] ##1 st_ff.cfg == AXR_CFG_SHARE)
    else $error("share change not refused");

  a_share_stop: assert property (
    st_ff.cfg == AXR_CFG_SHARE && sys_mode == AXR_MODE_STOP &&
    !st_ff.stop_keep |=> !reg_on)
    else $error("share not off in Stop");

  a_supply_low: assert property (
    supply_low && !st_ff.uv_keep |=> !reg_on)
    else $error("regulator on below supply threshold");

  a_share_noflag: assert property (
    st_ff.cfg == AXR_CFG_SHARE |->
    !ev_set[`AXR_EV_OC] && !ev_set[`AXR_EV_UV])
    else $error("flag raised in load sharing");

  a_oc_flag: assert property (
    shunt_limit && st_ff.cfg == AXR_CFG_ALONE
    |=> sts[`AXR_EV_OC] && $stable(st_ff.want))
    else $error("overcurrent flag missing");

  a_alone_switch: assert property (
    wr_en && hit_ctrl && st_ff.cfg == AXR_CFG_ALONE &&
    sys_mode == AXR_MODE_NORMAL && !soft_rst && !supply_low
    |=> reg_on == $past(pwdata[`AXR_CTRL_EN]))
    else $error("stand-alone switch ignored");

  a_uv_flag: assert property (
    reg_uv && reg_on && st_ff.cfg == AXR_CFG_ALONE |=> sts[`AXR_EV_UV])
    else $error("undervoltage flag missing");
endmodule // axr_ctrl

// ---- inc/axr_defines.svh ----
// Constants of the auxiliary regulator control block.
// Assumes an 8-bit APB byte address and 32-bit data.
`ifndef AXR_DEFINES_SVH
`define AXR_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define AXR_OFF_CTRL    8'h00
`define AXR_OFF_HWCTL   8'h04
`define AXR_OFF_STAT    8'h08
`define AXR_OFF_CLR     8'h0c
`define AXR_OFF_IEN     8'h10

// ****************************************
// Field positions
// ****************************************
`define AXR_CTRL_EN     0
`define AXR_CTRL_LVL    1
`define AXR_HW_LS       0
`define AXR_HW_STPKEEP  1
`define AXR_HW_UVKEEP   2
`define AXR_EV_OC       0
`define AXR_EV_UV       1
`define AXR_EV_ERR      2
`define AXR_STAT_LOCK   3
`define AXR_STAT_SHARE  4
`define AXR_STAT_ON     5
`define AXR_STAT_HP     6
`define AXR_STAT_LP     7
`define AXR_NEV         3

// ****************************************
// Reset values
// ****************************************
`define AXR_EV_RST      3'h0
`define AXR_RD_RST      32'h0000_0000

`endif

// ---- inc/axr_pkg.sv ----
// Types shared by the auxiliary regulator control block.
// Assumes the defines header is on the include path.
package axr_pkg;
  `include "axr_defines.svh"

  typedef enum logic [2:0] {
    AXR_MODE_INIT    = 3'h0,
    AXR_MODE_NORMAL  = 3'h1,
    AXR_MODE_STOP    = 3'h2,
    AXR_MODE_SLEEP   = 3'h3,
    AXR_MODE_RESTART = 3'h4,
    AXR_MODE_FAIL    = 3'h5
  } axr_mode_t;

  typedef enum logic [1:0] {
    AXR_CFG_NONE  = 2'h0,
    AXR_CFG_ALONE = 2'h1,
    AXR_CFG_SHARE = 2'h2
  } axr_cfg_t;

  typedef struct packed {
    axr_cfg_t    cfg;
    logic        en;
    logic        lvl;
    logic        stop_keep;
    logic        uv_keep;
    logic        want;
    logic        on;
    logic        v18;
    logic [31:0] rdata;
  } axr_main_st_t;

  typedef struct packed {
    logic [`AXR_NEV-1:0] sts;
    logic [`AXR_NEV-1:0] ien;
  } axr_irq_st_t;

  typedef struct packed {
    logic hp;
    logic lp;
  } axr_pwr_st_t;
endpackage

// ---- src/axr_irq.sv ----
// Sticky event flags, enable mask and the level interrupt.
// Assumes set and clear strobes are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
`include "axr_defines.svh"

module axr_irq (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                srst,
  // Events and software access
  input  wire logic [`AXR_NEV-1:0] ev_set,
  input  wire logic [`AXR_NEV-1:0] ev_clr,
  input  wire logic                ien_wr,
  input  wire logic [`AXR_NEV-1:0] ien_data,
  // Results
  output logic      [`AXR_NEV-1:0] sts,
  output logic      [`AXR_NEV-1:0] ien,
  output logic                     irq
);
  import axr_pkg::*;

  axr_irq_st_t st_ff;
  axr_irq_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // A new event wins over a clear in the same cycle
    nxt_st.sts = (st_ff.sts & ~ev_clr) | ev_set;
    if (ien_wr) begin
      nxt_st.ien = ien_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= {`AXR_EV_RST, `AXR_EV_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sts = st_ff.sts;
  assign ien = st_ff.ien;
  assign irq = |(st_ff.sts & st_ff.ien);

  a_set_wins: assert property (@(posedge sys_clk) disable iff (srst)
    (|ev_set) |=> ((sts & $past(ev_set)) == $past(ev_set)))
    else $error("event flag lost");
endmodule // axr_irq

// ---- src/axr_pwr_sel.sv ----
// Chooses low-power and high-power regulator stages.
// Assumes drive current comparator levels synchronous to sys_clk.
`timescale 1ns/1ps

module axr_pwr_sel (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // Operating state
  input  wire logic reg_on,
  input  wire logic low_pwr,
  // Drive current comparators
  input  wire logic drive_rise,
  input  wire logic drive_fall,
  // Stage enables
  output logic      hp_on,
  output logic      lp_on
);
  import axr_pkg::*;

  axr_pwr_st_t st_ff;
  axr_pwr_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!reg_on) begin
      nxt_st.hp = 1'b0;
      nxt_st.lp = 1'b0;
    end else if (!low_pwr) begin
      nxt_st.hp = 1'b1;
      nxt_st.lp = 1'b0;
    end else begin
      // Hysteresis: high-power stage helps only under heavy drive
      nxt_st.lp = 1'b1;
      if (drive_rise) begin
        nxt_st.hp = 1'b1;
      end else if (drive_fall) begin
        nxt_st.hp = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= 2'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hp_on = st_ff.hp;
  assign lp_on = st_ff.lp;

  a_hp_normal: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_on && !low_pwr) |=> (hp_on && !lp_on))
    else $error("normal mode must run high-power stage only");
endmodule // axr_pwr_sel

// ---- dv/axr_host.sv ----
// Host model: an APB master that programs the regulator control block.
// Assumes a single sys_clk and a slave that may insert wait states.
`timescale 1ns/1ps

module axr_host (
  // Clock
  input  wire logic        sys_clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Set when a transfer never got its answer
  output logic             hang
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hang = 1'b0;
  end

  // ****************************************
  // One transfer, held until pready is sampled high
  // ****************************************
  // The bench calls this for every register access, including the
  // status read and the Init-mode write made before the configuration is fixed.
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Bounded so a dead slave cannot hang the run
    // Blocking, so the caller sees it as soon as the task returns
    if (n >= 50) hang = 1'b1;
  endtask
endmodule // axr_host

// ---- dv/axr_ctrl_bench.sv ----
// Self-checking bench for the auxiliary regulator control block.
// Assumes the host model drives APB and the bench drives monitors.
`timescale 1ns/1ps
`include "axr_defines.svh"

module axr_ctrl_bench;
  import axr_pkg::*;
  logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic        soft_rst, supply_low, shunt_limit, reg_uv, hang;
  logic        drive_rise, drive_fall, reg_on, level_1v8, hp_on, lp_on;
  logic        irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  axr_mode_t   sys_mode;
  int          error_cnt, total_checks;

  axr_host i_host (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hang(hang));

  axr_ctrl i_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_mode(sys_mode), .soft_rst(soft_rst), .supply_low(supply_low),
    .shunt_limit(shunt_limit), .reg_uv(reg_uv), .drive_rise(drive_rise),
    .drive_fall(drive_fall), .reg_on(reg_on), .level_1v8(level_1v8),
    .hp_on(hp_on), .lp_on(lp_on), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    i_host.xfer(a, w, d, q, e);
    if (hang) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    bus(a, 1'b1, d, q, e);
  endtask

  // Only offsets above the enable register are unmapped here
  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] x);
    logic [31:0] q;
    logic e;
    bus(a, 1'b0, 32'h0, q, e);
    chk(n, x, q);
    chk("pslverr", {31'h0, a > `AXR_OFF_IEN}, {31'h0, e});
  endtask

  task automatic md(input axr_mode_t m);
    @(posedge sys_clk);
    sys_mode <= m;
    tick(3);
  endtask

  task automatic por();
    srst <= 1'b1;
    tick(12);
    srst <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  axr_mode_t mt[4] = '{AXR_MODE_SLEEP, AXR_MODE_RESTART, AXR_MODE_FAIL,
                       AXR_MODE_INIT};
  logic      mo[4] = '{1'b0, 1'b1, 1'b0, 1'b0};

  initial begin
    error_cnt = 0;
    total_checks = 0;
    srst = 1'b1;
    sys_mode = AXR_MODE_INIT;
    soft_rst = 1'b0;
    supply_low = 1'b0;
    shunt_limit = 1'b0;
    reg_uv = 1'b0;
    drive_rise = 1'b0;
    drive_fall = 1'b1;
    por();
    rchk("stat", `AXR_OFF_STAT, 32'h0);
    wr(`AXR_OFF_CTRL, 32'h1);
    rchk("stat", `AXR_OFF_STAT, 32'h0);
    chk("reg_on", 1'b0, reg_on);
    md(AXR_MODE_NORMAL);
    wr(`AXR_OFF_CTRL, 32'h3);
    tick(3);
    chk("reg_on", 1'b1, reg_on);
    chk("level_1v8", 1'b1, level_1v8);
    rchk("stat", `AXR_OFF_STAT, 32'h68);
    wr(`AXR_OFF_HWCTL, 32'h1);
    rchk("stat", `AXR_OFF_STAT, 32'h68);
    rchk("hwctl", `AXR_OFF_HWCTL, 32'h0);
    wr(`AXR_OFF_CTRL, 32'h0);
    tick(2);
    chk("reg_on", 1'b0, reg_on);
    wr(`AXR_OFF_CTRL, 32'h1);
    tick(3);
    chk("reg_on", 1'b1, reg_on);
    chk("level_1v8", 1'b0, level_1v8);
    md(AXR_MODE_STOP);
    chk("reg_on", 1'b1, reg_on);
    chk("hp_lp", 2'b01, {hp_on, lp_on});
    drive_fall <= 1'b0;
    drive_rise <= 1'b1;
    tick(3);
    chk("hp_lp", 2'b11, {hp_on, lp_on});
    drive_rise <= 1'b0;
    tick(3);
    chk("hp_on", 1'b1, hp_on);
    drive_fall <= 1'b1;
    tick(3);
    chk("hp_on", 1'b0, hp_on);
    md(AXR_MODE_NORMAL);
    chk("hp_lp", 2'b10, {hp_on, lp_on});
    supply_low <= 1'b1;
    tick(3);
    chk("reg_on", 1'b0, reg_on);
    supply_low <= 1'b0;
    tick(3);
    chk("reg_on", 1'b1, reg_on);
    wr(`AXR_OFF_HWCTL, 32'h4);
    supply_low <= 1'b1;
    tick(3);
    chk("reg_on", 1'b1, reg_on);
    supply_low <= 1'b0;
    wr(`AXR_OFF_IEN, 32'h7);
    shunt_limit <= 1'b1;
    tick(3);
    chk("irq", 1'b1, irq);
    // Clear while the limit still stands must not drop the flag
    wr(`AXR_OFF_CLR, 32'h1);
    rchk("stat", `AXR_OFF_STAT, 32'h69);
    shunt_limit <= 1'b0;
    wr(`AXR_OFF_CLR, 32'h1);
    tick(2);
    chk("irq", 1'b0, irq);
    reg_uv <= 1'b1;
    tick(2);
    reg_uv <= 1'b0;
    rchk("stat", `AXR_OFF_STAT, 32'h6a);
    chk("irq", 1'b1, irq);
    wr(`AXR_OFF_IEN, 32'h0);
    tick(2);
    chk("irq", 1'b0, irq);
    wr(`AXR_OFF_CLR, 32'h2);
    rchk("unmapped", 8'h20, 32'h0);
    @(posedge sys_clk);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    tick(3);
    rchk("stat", `AXR_OFF_STAT, 32'h08);
    wr(`AXR_OFF_HWCTL, 32'h1);
    rchk("stat", `AXR_OFF_STAT, 32'h08);
    // Power-on reset again, now for the load-sharing path
    por();
    wr(`AXR_OFF_HWCTL, 32'h1);
    tick(3);
    rchk("stat", `AXR_OFF_STAT, 32'h78);
    rchk("hwctl", `AXR_OFF_HWCTL, 32'h1);
    wr(`AXR_OFF_CTRL, 32'h3);
    tick(2);
    rchk("stat", `AXR_OFF_STAT, 32'h7c);
    chk("level_1v8", 1'b0, level_1v8);
    wr(`AXR_OFF_CLR, 32'h4);
    wr(`AXR_OFF_HWCTL, 32'h0);
    tick(2);
    rchk("stat", `AXR_OFF_STAT, 32'h7c);
    wr(`AXR_OFF_CLR, 32'h4);
    shunt_limit <= 1'b1;
    reg_uv <= 1'b1;
    tick(3);
    rchk("stat", `AXR_OFF_STAT, 32'h78);
    shunt_limit <= 1'b0;
    reg_uv <= 1'b0;
    md(AXR_MODE_STOP);
    chk("reg_on", 1'b0, reg_on);
    md(AXR_MODE_NORMAL);
    chk("reg_on", 1'b1, reg_on);
    for (int i = 0; i < 4; i++) begin
      md(mt[i]);
      chk("reg_on", mo[i], reg_on);
    end
    md(AXR_MODE_NORMAL);
    wr(`AXR_OFF_HWCTL, 32'h3);
    md(AXR_MODE_STOP);
    chk("reg_on", 1'b1, reg_on);
    tally_and_finish();
  end
endmodule // axr_ctrl_bench
